/* rtl/pil_pkg.sv */
// Shared constants for the priority interrupt logic and its sequencer end
package pil_pkg;
   // Pulse times of one word cycle: T24 down to T0, then Tp
   localparam int PT_W = 5;
   localparam logic [PT_W-1:0] PT_START = 5'h18;
   localparam logic [PT_W-1:0] PT_LAST = 5'h00;
   localparam logic [PT_W-1:0] PT_TP = 5'h19;
   localparam logic [PT_W-1:0] PT_WIN_HI = 5'h16;
   localparam logic [PT_W-1:0] PT_WIN_LO = 5'h11;
   localparam logic [PT_W-1:0] PT_SET_INT = 5'h0A;
   localparam logic [PT_W-1:0] PT_LOAD = 5'h09;
   // Channel set and vector lines
   localparam int CH_GROUP = 16;
   localparam int FIRST_SINGLE_CH = 5;
   localparam int VEC_W = 10;
   localparam int ADDR_W = 14;
   localparam logic [VEC_W-1:0] VECTOR_BASE_DEF = 10'h040;
   // Sequencer register map (byte addresses)
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam logic [3:0] REG_STATE = 4'hC;
   localparam int EV_W = 3;
   localparam int EV_ENTER = 0;
   localparam int EV_END = 1;
   localparam int EV_RESUME = 2;
   localparam int CTRL_RUN = 0;
   localparam int ST_HALT = 0;
   localparam int ST_PEND = 1;
   localparam int ST_END = 2;
   localparam int ST_VEC_LSB = 16;
   localparam logic [EV_W-1:0] MASK_RST = 3'h0;
   localparam logic CTRL_RUN_RST = 1'b1;
endpackage : pil_pkg

/* rtl/pil_link_if.sv */
// Link between the priority interrupt logic and the instruction sequencer
`timescale 1ns/1ns
`default_nettype none
interface pil_link_if;
   import pil_pkg::*;
   logic [PT_W-1:0] pulseTime;
   logic endCyclePhaseBit;
   logic memoryInterlaceActive;
   logic acknowledgeStrobe;
   logic serviceEndStrobe;
   logic forwardedRequest;
   logic singleInstructionActive;
   logic [VEC_W-1:0] vectorAddressLines;

   modport dev (
      input pulseTime, endCyclePhaseBit, memoryInterlaceActive,
      input acknowledgeStrobe, serviceEndStrobe,
      output forwardedRequest, singleInstructionActive, vectorAddressLines
   );
   modport seq (
      output pulseTime, endCyclePhaseBit, memoryInterlaceActive,
      output acknowledgeStrobe, serviceEndStrobe,
      input forwardedRequest, singleInstructionActive, vectorAddressLines
   );
endinterface : pil_link_if
`default_nettype wire

/* rtl/pil_priority_logic.sv */
// Priority interrupt logic: request latches, in-service flags, vector lines
// Overview of operation
// R1: Latch channel request only during T22..T17
// R2: Lower channel number means higher priority
// R3: Forward when latched, not in service, unblocked
// R4: Sequencer sets pending at T10 of end cycle
// R5: Pending releases a halt unless parity error or run bit clear
// R6: Pending suppresses program counter load at T9
// R7: Vector lines replace program counter at T9
// R8: Vector is fixed location of winning channel
// R9: Sequencer acknowledges next cycle, clears pending
// R10: Acknowledge marks top requesting channel in service
// R11: Higher channel nests inside lower serviced one
// R12: Earlier higher request takes the acknowledge
// R13: Channel set grows in groups of sixteen
// R14: Single-instruction indication ORs designated in-service flags
// R15: Indirect unconditional branch raises service-end strobe
// R16: Service end releases only top serviced channel
// R17: Single-instruction service holds counter, ends immediately
// R18: Reset clears latches, flags and pending
`timescale 1ns/1ns
`default_nettype none
module pil_priority_logic
   import pil_pkg::*;
#(
   parameter int NUM_GROUPS = 1,
   parameter logic [CH_GROUP*NUM_GROUPS-1:0] SINGLE_MASK = '0,
   parameter logic [VEC_W-1:0] VECTOR_BASE = VECTOR_BASE_DEF
) (
   input wire logic core_clk, // Word-cycle pulse clock
   input wire logic sys_rst, // Stop/reset, synchronous
   input wire logic clkEn, // Freezes all state while low
   input wire logic [CH_GROUP*NUM_GROUPS-1:0] channelLine, // Request lines, bit 0 first
   pil_link_if.dev link, // Sequencer side
   output logic [CH_GROUP*NUM_GROUPS-1:0] requestLatches, // Request latch per channel
   output logic [CH_GROUP*NUM_GROUPS-1:0] inServiceFlags, // In-service flag per channel
   output logic [$clog2(CH_GROUP*NUM_GROUPS+1)-1:0] nestDepth, // Channels in service, registered one clock late
   output logic anyRequest // Some request latch set
);
   localparam int NUM_CH = CH_GROUP * NUM_GROUPS; // R13
   localparam int IDX_W = $clog2(NUM_CH);
   localparam int CNT_W = $clog2(NUM_CH + 1);

   generate
      if (NUM_GROUPS < 1 || NUM_CH > (1 << VEC_W)) begin : gBadSize
         $error("NUM_GROUPS gives a channel set the vector lines cannot address");
      end
      if (SINGLE_MASK[FIRST_SINGLE_CH-1:0] != '0) begin : gBadMask
         $error("Only channels five and upward may be single-instruction channels");
      end
   endgenerate

   typedef struct packed {
      logic [NUM_CH-1:0] reqLatch;
      logic [NUM_CH-1:0] inService;
      logic ackSeen;
      logic endSeen;
      logic [VEC_W-1:0] vector;
      logic [CNT_W-1:0] depth;
   } pil_dev_state_s;

   pil_dev_state_s s;
   pil_dev_state_s next_s;

   logic inWindow;
   logic winAny;
   logic [IDX_W-1:0] winIdx;
   logic svcAny;
   logic [IDX_W-1:0] svcIdx;
   logic ackRise;
   logic endRise;
   logic [CNT_W-1:0] depthCount;

   // Lines and strobes count only inside the sampling window
   assign inWindow = (link.pulseTime <= PT_WIN_HI) && (link.pulseTime >= PT_WIN_LO); // R1

   // Highest-priority latched channel, scanned so the lowest index wins
   always_comb begin
      winAny = 1'b0;
      winIdx = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (s.reqLatch[i]) begin
            winAny = 1'b1; // R2
            winIdx = IDX_W'(i); // R2
         end
      end
   end

   // Highest-priority channel in service; nested lower ones sit below it
   always_comb begin
      svcAny = 1'b0;
      svcIdx = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (s.inService[i]) begin
            svcAny = 1'b1;
            svcIdx = IDX_W'(i);
         end
      end
   end

   always_comb begin
      depthCount = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         depthCount = depthCount + CNT_W'(s.inService[i]);
      end
   end

   // Strobes last several pulse times; act once on their leading edge
   assign ackRise = link.acknowledgeStrobe && inWindow && !s.ackSeen;
   assign endRise = link.serviceEndStrobe && inWindow && !s.endSeen;

   always_comb begin
      next_s = s;
      if (clkEn) begin
         next_s.ackSeen = link.acknowledgeStrobe && inWindow;
         next_s.endSeen = link.serviceEndStrobe && inWindow;
         if (endRise && svcAny) begin
            next_s.reqLatch[svcIdx] = 1'b0; // R16
            next_s.inService[svcIdx] = 1'b0; // R16
         end
         // A set in the same cycle as the release wins
         if (inWindow) begin
            next_s.reqLatch = next_s.reqLatch | channelLine; // R1
         end
         if (ackRise && winAny) begin
            next_s.inService[winIdx] = 1'b1; // R10 R12
         end
         // Vector of the current winner, held steady for the T9 load
         next_s.vector = VECTOR_BASE + VEC_W'(winIdx); // R8 R7
         next_s.depth = depthCount;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s <= '{vector: VECTOR_BASE, default: '0}; // R18
      end else begin
         s <= next_s;
      end
   end

   // A serviced channel keeps its latch, blocking all lower channels
   // while leaving higher ones free to interrupt it
   assign link.forwardedRequest = winAny && !s.inService[winIdx]; // R3 R11
   assign link.singleInstructionActive = |(s.inService & SINGLE_MASK); // R14 R17
   assign link.vectorAddressLines = s.vector; // R7

   assign requestLatches = s.reqLatch;
   assign inServiceFlags = s.inService;
   assign nestDepth = s.depth;
   assign anyRequest = winAny;
endmodule : pil_priority_logic
`default_nettype wire

/* rtl/pil_sequencer.sv */
// Instruction sequencer end: pulse timing, pending flag, address load, registers
`timescale 1ns/1ns
`default_nettype none
module pil_sequencer
   import pil_pkg::*;
(
   input wire logic core_clk, // Pulse clock
   input wire logic sys_rst, // Stop/reset, synchronous
   input wire logic clkEn, // Freezes all state while low
   pil_link_if.seq link, // Priority logic side
   input wire logic endCycleRequest, // Next word cycle is an end cycle
   input wire logic haltInstruction, // Halt instruction executed, pulse
   input wire logic parityErrorFlag, // Parity error stop
   input wire logic interlaceIn, // Memory interlace in progress
   input wire logic indirectBranch, // Indirect unconditional branch executing
   input wire logic [ADDR_W-1:0] programCounter, // Current program count
   output logic [ADDR_W-1:0] memAddress, // Address register contents
   output logic vectorToAddressLoad, // Vector loaded this T9, pulse
   output logic addressLoad, // Any address load this T9, pulse
   output logic programCounterHold, // Do not advance program counter
   output logic haltFlag, // Halted
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write
   input wire logic [3:0] wb_sel_i, // Wishbone byte select
   input wire logic [3:0] wb_adr_i, // Wishbone byte address
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   output logic irq // Level interrupt
);
   typedef struct packed {
      logic [PT_W-1:0] pulse;
      logic endCyc;
      logic intPend;
      logic halt;
      logic [ADDR_W-1:0] addr;
      logic vecLoad;
      logic anyLoad;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] mask;
      logic runSw;
      logic ack;
      logic [31:0] rdat;
   } pil_seq_state_s;

   pil_seq_state_s s;
   pil_seq_state_s next_s;
   logic inWindow;
   logic endStrobe;
   logic [EV_W-1:0] events;
   logic [31:0] rdMux;
   logic wrHit;

   assign inWindow = (s.pulse <= PT_WIN_HI) && (s.pulse >= PT_WIN_LO);
   assign endStrobe = inWindow && (indirectBranch // R15
      || (link.singleInstructionActive && !interlaceIn && s.endCyc)); // R17

   always_comb begin
      unique case (wb_adr_i)
         REG_STATUS: rdMux = 32'(s.status);
         REG_MASK: rdMux = 32'(s.mask);
         REG_CTRL: rdMux = 32'(s.runSw);
         REG_STATE: rdMux = {6'h00, link.vectorAddressLines, 13'h0000,
            s.endCyc, s.intPend, s.halt};
         default: rdMux = 32'h00000000;
      endcase
   end

   assign wrHit = s.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];

   always_comb begin
      next_s = s;
      events = '0;
      if (clkEn) begin
         next_s.vecLoad = 1'b0;
         next_s.anyLoad = 1'b0;
         unique case (s.pulse)
            PT_TP: next_s.pulse = PT_START;
            PT_LAST: next_s.pulse = PT_TP;
            default: next_s.pulse = s.pulse - 5'h01;
         endcase
         if (s.pulse == PT_TP) begin
            next_s.endCyc = endCycleRequest;
         end
         if (haltInstruction) begin
            next_s.halt = 1'b1;
         end
         if (s.pulse == PT_SET_INT) begin
            if (s.endCyc && link.forwardedRequest && !s.intPend) begin
               next_s.intPend = 1'b1; // R4
               events[EV_ENTER] = 1'b1;
               if (s.halt && s.runSw && !parityErrorFlag) begin
                  next_s.halt = 1'b0; // R5
                  events[EV_RESUME] = 1'b1;
               end
            end else if (s.intPend && !s.endCyc) begin
               next_s.intPend = 1'b0; // R9
            end
         end
         if (s.pulse == PT_LOAD && s.endCyc) begin
            if (!s.intPend) begin
               next_s.addr = programCounter;
               next_s.anyLoad = 1'b1;
            end else if (!interlaceIn) begin // R6
               next_s.addr = ADDR_W'(link.vectorAddressLines); // R7
               next_s.vecLoad = 1'b1;
               next_s.anyLoad = 1'b1;
            end
         end
         if (endStrobe && s.pulse == PT_WIN_HI) begin
            events[EV_END] = 1'b1;
         end
         next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
         next_s.rdat = rdMux;
         if (wrHit && wb_adr_i == REG_STATUS) begin
            next_s.status = s.status & ~wb_dat_i[EV_W-1:0];
         end
         if (wrHit && wb_adr_i == REG_MASK) begin
            next_s.mask = wb_dat_i[EV_W-1:0];
         end
         if (wrHit && wb_adr_i == REG_CTRL) begin
            next_s.runSw = wb_dat_i[CTRL_RUN];
         end
         // An event in the clearing cycle stays set
         next_s.status = next_s.status | events;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s <= '{pulse: PT_START, mask: MASK_RST, runSw: CTRL_RUN_RST, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign link.pulseTime = s.pulse;
   assign link.endCyclePhaseBit = s.endCyc;
   assign link.memoryInterlaceActive = interlaceIn;
   assign link.acknowledgeStrobe = s.intPend && !s.endCyc && inWindow; // R9
   assign link.serviceEndStrobe = endStrobe;
   assign programCounterHold = link.singleInstructionActive; // R17
   assign memAddress = s.addr;
   assign vectorToAddressLoad = s.vecLoad;
   assign addressLoad = s.anyLoad;
   assign haltFlag = s.halt;
   assign wb_dat_o = s.rdat;
   // A frozen slave must not show an acknowledge it cannot complete
   assign wb_ack_o = s.ack && clkEn;
   assign irq = |(s.status & s.mask);
endmodule : pil_sequencer
`default_nettype wire

/* dv/pil_link_props.sv */
// Concurrent checks on the link between priority logic and sequencer
`timescale 1ns/1ns
`default_nettype none
module pil_link_props
   import pil_pkg::*;
(
   input wire logic core_clk, // Pulse clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic clkEn, // Clock enable of both ends
   input wire logic [PT_W-1:0] pulseTime, // Pulse time
   input wire logic endCyclePhaseBit, // End cycle
   input wire logic memoryInterlaceActive, // Interlace
   input wire logic acknowledgeStrobe, // Acknowledge
   input wire logic serviceEndStrobe, // Service end
   input wire logic forwardedRequest, // Request to sequencer
   input wire logic singleInstructionActive, // Single-instruction service
   input wire logic [VEC_W-1:0] vectorAddressLines // Vector lines
);
   // Frozen cycles are no steps of the word cycle
   default clocking cb @(posedge core_clk iff clkEn); endclocking
   default disable iff (sys_rst);
   logic inWin;
   assign inWin = pulseTime <= PT_WIN_HI && pulseTime >= PT_WIN_LO;
   sequence ackBurst;
      acknowledgeStrobe [*6] ##1 !acknowledgeStrobe;
   endsequence
   sequence pendAtT10;
      forwardedRequest && endCyclePhaseBit && pulseTime == PT_SET_INT;
   endsequence
   chk_pulse_wrap: assert property (pulseTime == PT_LAST |=> pulseTime == PT_TP)
      else $error("pulse time does not reach Tp");
   chk_cycle_start: assert property (pulseTime == PT_TP |=> pulseTime == PT_START)
      else $error("word cycle does not restart");
   chk_pulse_count: assert property (!sys_rst && pulseTime != PT_LAST && pulseTime != PT_TP
      |=> pulseTime == $past(pulseTime) - 5'h01)
      else $error("pulse time skipped");
   chk_ack_window: assert property (acknowledgeStrobe |-> inWin && !endCyclePhaseBit)
      else $error("acknowledge outside its window");
   chk_ack_burst: assert property ($rose(acknowledgeStrobe) |-> pulseTime == PT_WIN_HI ##0 ackBurst)
      else $error("acknowledge has wrong length");
   chk_end_window: assert property (serviceEndStrobe |-> inWin)
      else $error("service end outside its window");
   chk_req_to_ack: assert property (pendAtT10 |-> ##[13:15] acknowledgeStrobe)
      else $error("request never acknowledged");
   chk_single_end: assert property (singleInstructionActive && endCyclePhaseBit && inWin
      && !memoryInterlaceActive |-> serviceEndStrobe)
      else $error("single-instruction service not ended");
   chk_vector_range: assert property (vectorAddressLines >= VECTOR_BASE_DEF
      && vectorAddressLines < VECTOR_BASE_DEF + 10'h010)
      else $error("vector outside channel block");
   chk_reset_clear: assert property ($fell(sys_rst) |-> !forwardedRequest
      && !singleInstructionActive && pulseTime == PT_START)
      else $error("state not cleared by reset");
endmodule : pil_link_props
`default_nettype wire

/* dv/pil_bench.sv */
// Self-checking bench joining priority logic and sequencer
`timescale 1ns/1ns
`default_nettype none
module priority_interrupt_logic_bench
   import pil_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic endCycleRequest = 1'b0;
   logic haltInstruction = 1'b0;
   logic parityErrorFlag = 1'b0;
   logic indirectBranch = 1'b0;
   logic clkEn = 1'b1;
   logic interlace = 1'b0;
   logic [15:0] channelLine = 16'h0000;
   logic [ADDR_W-1:0] programCounter = 14'h1A5C;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [3:0] wbAdr = 4'h0;
   logic [31:0] wbDat = 32'h0;
   logic [31:0] wbRd;
   logic wbAck, irq, haltFlag, programCounterHold, vectorToAddressLoad;
   logic [ADDR_W-1:0] memAddress;
   logic [15:0] requestLatches, inServiceFlags;
   logic [4:0] nestDepth;
   logic anyRequest, addressLoad;
   logic [31:0] seed;
   int err_count = 0;
   int n_compared = 0;
   pil_link_if link ();
   pil_priority_logic #(.NUM_GROUPS(1), .SINGLE_MASK(16'h0020)) i_pil_priority_logic (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .channelLine(channelLine),
      .link(link.dev), .requestLatches(requestLatches), .inServiceFlags(inServiceFlags),
      .nestDepth(nestDepth), .anyRequest(anyRequest));
   pil_sequencer i_pil_sequencer (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .link(link.seq),
      .endCycleRequest(endCycleRequest), .haltInstruction(haltInstruction),
      .parityErrorFlag(parityErrorFlag), .interlaceIn(interlace),
      .indirectBranch(indirectBranch),
      .programCounter(programCounter), .memAddress(memAddress),
      .vectorToAddressLoad(vectorToAddressLoad), .addressLoad(addressLoad),
      .programCounterHold(programCounterHold), .haltFlag(haltFlag), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_sel_i(4'hF), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
      .wb_dat_o(wbRd), .wb_ack_o(wbAck), .irq(irq));
   pil_link_props i_pil_link_props (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .pulseTime(link.pulseTime),
      .endCyclePhaseBit(link.endCyclePhaseBit), .memoryInterlaceActive(link.memoryInterlaceActive),
      .acknowledgeStrobe(link.acknowledgeStrobe), .serviceEndStrobe(link.serviceEndStrobe),
      .forwardedRequest(link.forwardedRequest),
      .singleInstructionActive(link.singleInstructionActive),
      .vectorAddressLines(link.vectorAddressLines));
   always #4 core_clk = ~core_clk;
   // End cycles alternate so every pending request meets a non-end cycle
   always @(posedge core_clk) begin
      if (clkEn && link.pulseTime === PT_LAST) endCycleRequest <= !endCycleRequest;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic int low(input logic [15:0] v);
      low = 0;
      for (int i = 15; i >= 0; i--) if (v[i]) low = i;
   endfunction : low
   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] act);
      n_compared++;
      if (act !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, act);
      end
   endtask : cmp
   // Codes below 32 wait for a pulse time, 32 vector load, 33 acknowledge, 34 idle
   task automatic wait_on(input int w);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < 200 && !hit; k++) begin
         @(posedge core_clk);
         case (w)
            32: hit = vectorToAddressLoad === 1'b1;
            33: hit = link.acknowledgeStrobe === 1'b1;
            34: hit = inServiceFlags === 16'h0000;
            default: hit = link.pulseTime === 5'(w);
         endcase
      end
      if (!hit) begin
         err_count++;
         complete_run();
      end
   endtask : wait_on
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int k;
      @(posedge core_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDat <= d;
      for (k = 0; k < 20; k++) begin
         @(posedge core_clk);
         if (wbAck === 1'b1) break;
      end
      q = wbRd;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (k == 20) begin
         err_count++;
         complete_run();
      end
   endtask : wb
   task automatic serve(input logic [15:0] lines, input int idx);
      if (lines != 16'h0000) begin
         wait_on(PT_WIN_HI);
         channelLine <= lines;
         wait_on(PT_WIN_LO);
         channelLine <= 16'h0000;
      end
      wait_on(32);
      cmp("vector", 32'(VECTOR_BASE_DEF + 10'(idx)), 32'(memAddress[VEC_W-1:0]));
      cmp("address load", 32'h1, 32'(addressLoad));
      wait_on(33);
      wait_on(16);
      cmp("in service", 32'h1, 32'(inServiceFlags[idx]));
   endtask : serve
   task automatic finish(input logic [15:0] expSvc);
      indirectBranch <= 1'b1;
      wait_on(PT_WIN_LO);
      indirectBranch <= 1'b0;
      wait_on(16);
      cmp("service end", 32'(expSvc), 32'(inServiceFlags));
   endtask : finish
   initial begin
      logic [31:0] q;
      logic [31:0] lat;
      logic [15:0] ln;
      int idx;
      logic [PT_W-1:0] frzPt;
      seed = 32'h3e80504f;
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      cmp("latches", 32'h0, 32'(requestLatches | inServiceFlags));
      wb(1'b0, REG_MASK, 32'h0, q);
      cmp("mask", 32'(MASK_RST), q);
      wb(1'b0, REG_CTRL, 32'h0, q);
      cmp("ctrl", 32'(CTRL_RUN_RST), q);
      wb(1'b0, 4'h6, 32'h0, q);
      cmp("unmapped", 32'h0, q);
      wb(1'b0, REG_STATE, 32'h0, q);
      cmp("state", 32'(VECTOR_BASE_DEF) << ST_VEC_LSB, q);
      wait_on(PT_SET_INT);
      channelLine <= 16'h0008;
      wait_on(5'h01);
      channelLine <= 16'h0000;
      wait_on(PT_START);
      cmp("outside window", 32'h0, 32'(requestLatches));
      wb(1'b1, REG_MASK, 32'h1 << EV_ENTER, q);
      serve(16'h0018, 3);
      cmp("irq set", 32'h1, 32'(irq));
      cmp("any request", 32'h1, 32'(anyRequest));
      // Clock enable low for a random stretch must hold all state
      seed = xs(seed);
      clkEn <= 1'b0;
      @(posedge core_clk);
      frzPt = link.pulseTime;
      repeat (2 + int'(seed[2:0])) @(posedge core_clk);
      cmp("frozen flags", 32'h00180008, 32'({requestLatches, inServiceFlags}));
      cmp("frozen pulse", 32'(frzPt), 32'(link.pulseTime));
      clkEn <= 1'b1;
      wb(1'b1, REG_STATUS, 32'h7, q);
      @(posedge core_clk);
      cmp("irq clear", 32'h0, 32'(irq));
      serve(16'h0002, 1);
      cmp("depth", 32'h2, 32'(nestDepth));
      finish(16'h0008);
      finish(16'h0000);
      serve(16'h0000, 4);
      finish(16'h0000);
      for (int i = 1; i >= 0; i--) begin
         parityErrorFlag <= 1'(i);
         haltInstruction <= 1'b1;
         @(posedge core_clk);
         haltInstruction <= 1'b0;
         serve(16'h0004, 2);
         cmp("halt", 32'(i), 32'(haltFlag));
         finish(16'h0000);
      end
      // Interlace at the load time keeps the old address, service still starts
      interlace <= 1'b1;
      wait_on(PT_WIN_HI);
      channelLine <= 16'h0040;
      wait_on(PT_WIN_LO);
      channelLine <= 16'h0000;
      wait_on(33);
      cmp("interlace address", 32'(programCounter), 32'(memAddress));
      interlace <= 1'b0;
      wait_on(16);
      cmp("interlace service", 32'h1, 32'(inServiceFlags[6]));
      finish(16'h0000);
      serve(16'h0020, 5);
      cmp("single", 32'h1, 32'(link.singleInstructionActive));
      cmp("hold", 32'h1, 32'(programCounterHold));
      wait_on(34);
      cmp("single latch", 32'h0, 32'(requestLatches));
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         lat = seed & 32'h0000FFDF;
         if (lat == 32'h0) lat = 32'h1;
         ln = lat[15:0];
         while (lat != 32'h0) begin
            idx = low(lat[15:0]);
            serve(ln, idx);
            ln = 16'h0000;
            finish(16'h0000);
            lat[idx] = 1'b0;
         end
         cmp("drained", 32'h0, 32'(requestLatches));
         cmp("no request", 32'h0, 32'(anyRequest));
      end
      // Stop/reset in mid-run drops a fresh request
      wait_on(PT_WIN_HI);
      channelLine <= 16'h0100;
      wait_on(PT_WIN_LO);
      channelLine <= 16'h0000;
      sys_rst <= 1'b1;
      cmp("latched", 32'h0100, 32'(requestLatches));
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      cmp("reset flags", 32'h0, 32'({requestLatches, inServiceFlags}));
      complete_run();
   end
endmodule : priority_interrupt_logic_bench
`default_nettype wire
